// file: inc/cdp_cfg.svh
// constants of the coupler diagnostic and process image block
// Notes on behaviour
// - coupler adds its own 8-byte status record to the cyclic image
// - record sits at start of input area 3, before module inputs
// - word 0 bit 0 is the new-diagnosis flag, other bits zero
// - word 1 mirrors the local bus diagnostic status once two synced samples agree
// - word 2 holds the error code of the latest module error
// - word 3 holds the position of the module in error
// - words 1 to 3 readable acyclically with identical values
// - 16, 32 and 64 bit module data get per-width byte order
// - order bit true means little endian, false big; default little
// - byte order settings are kept across power cycles
// - state machine error sets status error bit and writes code
// - codes 0000 no error, 0011 bad change, 0012 unknown state
// - code 0016 for invalid mailbox configuration
// - code 001B when process data watchdog expires
// - code 001D bad output config, 001E bad input config
// - code 0028 when sync mode asked but no module supports it
// - emergency messages are sent with no acknowledge expected
// - emergency message is 2 byte code, 1 byte register, 5 data
// - bus error: code 1000, register 80, slot, bus code, zero
// - I/O error: own code, register 80, slot, location, prio, zero
`ifndef CDP_CFG_SVH
`define CDP_CFG_SVH
// ==========================================
// record layout
`define CDP_REC_BYTES      8
`define CDP_REC_SM         2'h3
`define CDP_OFS_NEW_DIAG   3'h0
`define CDP_OFS_BUS_STATE  3'h2
`define CDP_OFS_ERR_CODE   3'h4
`define CDP_OFS_ERR_POS    3'h6
// ==========================================
// status codes
`define CDP_AL_NONE        16'h0000
`define CDP_AL_BAD_CHANGE  16'h0011
`define CDP_AL_UNKNOWN     16'h0012
`define CDP_AL_MBX_CFG     16'h0016
`define CDP_AL_WATCHDOG    16'h001B
`define CDP_AL_OUT_CFG     16'h001D
`define CDP_AL_IN_CFG      16'h001E
`define CDP_AL_NO_SYNC     16'h0028
// ==========================================
// emergency message
`define CDP_EMCY_BYTES     8
`define CDP_EMCY_BUS_CODE  16'h1000
`define CDP_EMCY_REG       8'h80
// ==========================================
// byte order defaults, 1 = little endian
`define CDP_ORDER_DEFAULT  3'h7
`endif

// file: inc/cdp_pkg.sv
// types of the coupler diagnostic and process image block
package cdp_pkg;
  typedef enum logic [1:0] {
    CDP_W8  = 2'b00,
    CDP_W16 = 2'b01,
    CDP_W32 = 2'b10,
    CDP_W64 = 2'b11
  } cdp_width_e;
  typedef enum logic [1:0] {
    CDP_EM_IDLE = 2'b00,
    CDP_EM_SEND = 2'b01
  } cdp_emcy_state_e;
endpackage : cdp_pkg

// file: inc/cdp_swap_if.sv
// carrier between the top and the byte order unit
`timescale 1ns/1ps
interface cdp_swap_if;
  logic [63:0] data_in;
  logic [1:0]  width;
  logic [2:0]  order;
  logic [63:0] data_out;
  modport top  (output data_in, output width, output order, input data_out);
  modport unit (input data_in, input width, input order, output data_out);
endinterface : cdp_swap_if

// file: core/cdp_swap.sv
// byte order unit for module data items
`timescale 1ns/1ps
module cdp_swap (
  cdp_swap_if.unit sw
);
  // ==========================================
  // reverse the low n bytes of a word
  function automatic logic [63:0] cdp_rev(input logic [63:0] d,
                                          input int unsigned n);
    logic [63:0] r;
    r = d;
    for (int unsigned i = 0; i < 8; i++)
      if (i < n)
        r[8*i +: 8] = d[8*(n-1-i) +: 8];
    return r;
  endfunction : cdp_rev

  // ==========================================
  // big endian on the local bus, swapped when little is chosen
  always_comb
  begin
    sw.data_out = sw.data_in;
    unique case (cdp_pkg::cdp_width_e'(sw.width))
      cdp_pkg::CDP_W8:  sw.data_out = sw.data_in;
      cdp_pkg::CDP_W16:
        if (sw.order[0])
          sw.data_out = cdp_rev(sw.data_in, 2);
      cdp_pkg::CDP_W32:
        if (sw.order[1])
          sw.data_out = cdp_rev(sw.data_in, 4);
      cdp_pkg::CDP_W64:
        if (sw.order[2])
          sw.data_out = cdp_rev(sw.data_in, 8);
    endcase
  end
endmodule : cdp_swap

// file: core/cdp_top.sv
// coupler diagnostic record, status code and emergency formatter
`timescale 1ns/1ps
`include "cdp_cfg.svh"
module cdp_top (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RST_B,
  // diagnostic sources
  input  wire logic [15:0] BUS_STATE,
  input  wire logic        MOD_ERR_STB,
  input  wire logic [15:0] MOD_ERR_CODE,
  input  wire logic [15:0] MOD_ERR_POS,
  input  wire logic [7:0]  MOD_ERR_LOC,
  input  wire logic [7:0]  MOD_ERR_PRIO,
  input  wire logic        BUS_ERR_STB,
  input  wire logic [15:0] BUS_ERR_SLOT,
  input  wire logic [15:0] BUS_ERR_CODE,
  input  wire logic        DIAG_STORED_STB,
  input  wire logic        DIAG_ACK_STB,
  // state machine errors, one-hot pulses
  input  wire logic        SM_ERR_BAD_CHANGE,
  input  wire logic        SM_ERR_UNKNOWN,
  input  wire logic        SM_ERR_MBX_CFG,
  input  wire logic        SM_ERR_WATCHDOG,
  input  wire logic        SM_ERR_OUT_CFG,
  input  wire logic        SM_ERR_IN_CFG,
  input  wire logic        SM_ERR_NO_SYNC,
  input  wire logic        SM_ERR_CLEAR,
  // application layer status
  output logic             AL_ERROR,
  output logic      [15:0] AL_CODE,
  // process image read port, input area
  input  wire logic [1:0]  PI_SM,
  input  wire logic [15:0] PI_ADDR,
  output logic      [7:0]  PI_DATA,
  output logic             PI_MODULE,
  output logic      [15:0] PI_MODULE_ADDR,
  // acyclic read port, word index 1..3
  input  wire logic [1:0]  MBX_WORD,
  output logic      [15:0] MBX_DATA,
  // byte order settings, stored retentively
  input  wire logic        ORDER_WR,
  input  wire logic [2:0]  ORDER_WDATA,
  input  wire logic [2:0]  ORDER_NV,
  input  wire logic        ORDER_NV_VALID,
  output logic      [2:0]  ORDER,
  output logic             ORDER_NV_WR,
  // module data mapping
  input  wire logic [63:0] ITEM_IN,
  input  wire logic [1:0]  ITEM_WIDTH,
  output logic      [63:0] ITEM_OUT,
  // emergency message stream
  output logic             EMCY_VALID,
  output logic      [7:0]  EMCY_BYTE,
  output logic             EMCY_LAST
);
  // ==========================================
  // record state
  logic        new_diag, next_new_diag;
  logic [15:0] err_code, next_err_code;
  logic [15:0] err_pos, next_err_pos;
  logic [15:0] bus_sync1, bus_sync2, bus_sync3;
  logic [15:0] bus_word, next_bus_word;
  logic [63:0] record;

  always_comb
  begin
    next_new_diag = new_diag;
    if (DIAG_ACK_STB)
      next_new_diag = 1'b0;
    if (DIAG_STORED_STB)
      next_new_diag = 1'b1;
    next_err_code = err_code;
    next_err_pos  = err_pos;
    // take the synced word only once two samples agree
    next_bus_word = bus_word;
    if (bus_sync2 == bus_sync3)
      next_bus_word = bus_sync2;
    if (MOD_ERR_STB)
    begin
      next_err_code = MOD_ERR_CODE;
      next_err_pos  = MOD_ERR_POS;
    end
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      new_diag  <= 1'b0;
      err_code  <= 16'h0000;
      err_pos   <= 16'h0000;
      bus_sync1 <= 16'h0000;
      bus_sync2 <= 16'h0000;
      bus_sync3 <= 16'h0000;
      bus_word  <= 16'h0000;
    end
    else
    begin
      new_diag  <= next_new_diag;
      err_code  <= next_err_code;
      err_pos   <= next_err_pos;
      bus_sync1 <= BUS_STATE;
      bus_sync2 <= bus_sync1;
      bus_sync3 <= bus_sync2;
      bus_word  <= next_bus_word;
    end
  end

  // word 0 carries only the flag, low byte first in each word
  assign record = {err_pos, err_code, bus_word, 15'h0000, new_diag};

  // ==========================================
  // process image read
  logic [7:0]  next_pi_data;
  logic        in_rec;

  assign in_rec = (PI_SM == `CDP_REC_SM) &&
                  (PI_ADDR < 16'(`CDP_REC_BYTES));

  always_comb
  begin
    next_pi_data = 8'h00;
    if (in_rec)
      next_pi_data = record[8*PI_ADDR[2:0] +: 8];
  end

  // module bytes shifted behind the record
  assign PI_MODULE      = (PI_SM == `CDP_REC_SM) && !in_rec;
  assign PI_MODULE_ADDR = PI_ADDR - 16'(`CDP_REC_BYTES);

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      PI_DATA <= 8'h00;
    else
      PI_DATA <= next_pi_data;
  end

  // ==========================================
  // acyclic read of words 1..3, same sources as the image
  logic [15:0] next_mbx_data;

  always_comb
  begin
    next_mbx_data = 16'h0000;
    unique case (MBX_WORD)
      2'h1:    next_mbx_data = record[31:16];
      2'h2:    next_mbx_data = record[47:32];
      2'h3:    next_mbx_data = record[63:48];
      default: next_mbx_data = 16'h0000;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      MBX_DATA <= 16'h0000;
    else
      MBX_DATA <= next_mbx_data;
  end

  // ==========================================
  // application layer status
  logic        next_al_error;
  logic [15:0] next_al_code;

  always_comb
  begin
    next_al_error = AL_ERROR;
    next_al_code  = AL_CODE;
    if (SM_ERR_CLEAR)
    begin
      next_al_error = 1'b0;
      next_al_code  = `CDP_AL_NONE;
    end
    if (SM_ERR_BAD_CHANGE | SM_ERR_UNKNOWN | SM_ERR_MBX_CFG |
        SM_ERR_WATCHDOG | SM_ERR_OUT_CFG | SM_ERR_IN_CFG | SM_ERR_NO_SYNC)
      next_al_error = 1'b1;
    if (SM_ERR_BAD_CHANGE)
      next_al_code = `CDP_AL_BAD_CHANGE;
    else if (SM_ERR_UNKNOWN)
      next_al_code = `CDP_AL_UNKNOWN;
    else if (SM_ERR_MBX_CFG)
      next_al_code = `CDP_AL_MBX_CFG;
    else if (SM_ERR_WATCHDOG)
      next_al_code = `CDP_AL_WATCHDOG;
    else if (SM_ERR_OUT_CFG)
      next_al_code = `CDP_AL_OUT_CFG;
    else if (SM_ERR_IN_CFG)
      next_al_code = `CDP_AL_IN_CFG;
    else if (SM_ERR_NO_SYNC)
      next_al_code = `CDP_AL_NO_SYNC;
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      AL_ERROR <= 1'b0;
      AL_CODE  <= `CDP_AL_NONE;
    end
    else
    begin
      AL_ERROR <= next_al_error;
      AL_CODE  <= next_al_code;
    end
  end

  // ==========================================
  // byte order settings
  logic [2:0] next_order;
  logic       loaded, next_loaded;
  logic       next_nv_wr;

  always_comb
  begin
    next_order  = ORDER;
    next_loaded = loaded;
    next_nv_wr  = 1'b0;
    if (!loaded)
    begin
      next_loaded = 1'b1;
      if (ORDER_NV_VALID)
        next_order = ORDER_NV;
    end
    else if (ORDER_WR)
    begin
      next_order = ORDER_WDATA;
      next_nv_wr = 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      ORDER       <= `CDP_ORDER_DEFAULT;
      loaded      <= 1'b0;
      ORDER_NV_WR <= 1'b0;
    end
    else
    begin
      ORDER       <= next_order;
      loaded      <= next_loaded;
      ORDER_NV_WR <= next_nv_wr;
    end
  end

  cdp_swap_if sw ();
  assign sw.data_in = ITEM_IN;
  assign sw.width   = ITEM_WIDTH;
  assign sw.order   = ORDER;

  cdp_swap u_swap (
    .sw (sw.unit)
  );

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
      ITEM_OUT <= 64'h0000_0000_0000_0000;
    else
      ITEM_OUT <= sw.data_out;
  end

  // ==========================================
  // emergency message sender, no acknowledge awaited
  cdp_pkg::cdp_emcy_state_e em_state, next_em_state;
  logic [63:0] em_msg, next_em_msg;
  logic [2:0]  em_idx, next_em_idx;

  always_comb
  begin
    next_em_state = em_state;
    next_em_msg   = em_msg;
    next_em_idx   = em_idx;
    unique case (em_state)
      cdp_pkg::CDP_EM_IDLE:
      begin
        next_em_idx = 3'h0;
        if (BUS_ERR_STB)
        begin
          next_em_msg = {8'h00, BUS_ERR_CODE[7:0], BUS_ERR_CODE[15:8],
                         BUS_ERR_SLOT[7:0], BUS_ERR_SLOT[15:8],
                         `CDP_EMCY_REG,
                         `CDP_EMCY_BUS_CODE};
          next_em_state = cdp_pkg::CDP_EM_SEND;
        end
        else if (MOD_ERR_STB)
        begin
          next_em_msg = {8'h00, MOD_ERR_PRIO, MOD_ERR_LOC,
                         MOD_ERR_POS[7:0], MOD_ERR_POS[15:8],
                         `CDP_EMCY_REG, MOD_ERR_CODE};
          next_em_state = cdp_pkg::CDP_EM_SEND;
        end
      end
      cdp_pkg::CDP_EM_SEND:
      begin
        next_em_idx = em_idx + 3'h1;
        if (em_idx == 3'(`CDP_EMCY_BYTES - 1))
          next_em_state = cdp_pkg::CDP_EM_IDLE;
      end
      default: next_em_state = cdp_pkg::CDP_EM_IDLE;
    endcase
  end

  always_ff @(posedge CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      em_state <= cdp_pkg::CDP_EM_IDLE;
      em_msg   <= 64'h0000_0000_0000_0000;
      em_idx   <= 3'h0;
    end
    else
    begin
      em_state <= next_em_state;
      em_msg   <= next_em_msg;
      em_idx   <= next_em_idx;
    end
  end

  // code is sent high byte first, then register and data
  always_comb
  begin
    EMCY_BYTE = 8'h00;
    unique case (em_idx)
      3'h0:    EMCY_BYTE = em_msg[15:8];
      3'h1:    EMCY_BYTE = em_msg[7:0];
      default: EMCY_BYTE = em_msg[8*em_idx +: 8];
    endcase
  end
  assign EMCY_VALID = (em_state == cdp_pkg::CDP_EM_SEND);
  assign EMCY_LAST  = EMCY_VALID &&
                      (em_idx == 3'(`CDP_EMCY_BYTES - 1));
endmodule : cdp_top

// file: test/cdp_top_checker.sv
// assertions on the ports of the diagnostic block
`timescale 1ns/1ps
module cdp_top_checker (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RST_B,
  // watched inputs
  input wire logic        SM_ERR_BAD_CHANGE,
  input wire logic        BUS_ERR_STB,
  input wire logic [1:0]  PI_SM,
  input wire logic [15:0] PI_ADDR,
  input wire logic [1:0]  MBX_WORD,
  input wire logic        ORDER_WR,
  input wire logic [2:0]  ORDER_WDATA,
  // watched outputs
  input wire logic        AL_ERROR,
  input wire logic [15:0] AL_CODE,
  input wire logic [7:0]  PI_DATA,
  input wire logic        PI_MODULE,
  input wire logic [15:0] PI_MODULE_ADDR,
  input wire logic [15:0] MBX_DATA,
  input wire logic [2:0]  ORDER,
  input wire logic        ORDER_NV_WR,
  input wire logic        EMCY_VALID,
  input wire logic [7:0]  EMCY_BYTE,
  input wire logic        EMCY_LAST
);
  // ====================
  // properties
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  al_pair_a: assert property (
    AL_ERROR == (AL_CODE != 16'h0000))
    else $error("status bit and code disagree");
  al_bad_a: assert property (
    SM_ERR_BAD_CHANGE |=> AL_ERROR && AL_CODE == 16'h0011)
    else $error("bad change code missing");
  rec_flag_a: assert property (
    PI_SM == 2'h3 && PI_ADDR == 16'h1 |=> PI_DATA == 8'h00)
    else $error("record byte 1 not zero");
  rec_mbx_a: assert property (
    PI_SM == 2'h3 && PI_ADDR == 16'h4 && MBX_WORD == 2'h2
    |=> PI_DATA == MBX_DATA[7:0])
    else $error("image and mailbox differ");
  mod_area_a: assert property (
    PI_SM == 2'h3 && PI_ADDR >= 16'h8
    |-> PI_MODULE && PI_MODULE_ADDR == PI_ADDR - 16'h8)
    else $error("module area offset wrong");
  emcy_frame_a: assert property (
    $rose(EMCY_VALID) |-> (EMCY_VALID && !EMCY_LAST) [*7]
    ##1 (EMCY_VALID && EMCY_LAST) ##1 !EMCY_VALID)
    else $error("message not eight bytes");
  emcy_reg_a: assert property (
    $rose(EMCY_VALID) |-> ##2 EMCY_BYTE == 8'h80)
    else $error("error register byte wrong");
  emcy_tail_a: assert property (
    EMCY_LAST |-> EMCY_BYTE == 8'h00)
    else $error("last byte not zero");
  emcy_bus_a: assert property (
    BUS_ERR_STB && !EMCY_VALID |=> EMCY_VALID && EMCY_BYTE == 8'h10)
    else $error("bus message not started");
  order_wr_a: assert property (
    ORDER_WR |=> ORDER == $past(ORDER_WDATA) && ORDER_NV_WR)
    else $error("order write not stored");
  cover property ($rose(EMCY_VALID));
  cover property (ORDER_NV_WR);
  cover property ($rose(AL_ERROR));
endmodule : cdp_top_checker

// file: test/cdp_master_model.sv
// fieldbus master model collecting emergency messages
`timescale 1ns/1ps
module cdp_master_model (
  // clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // emergency stream, nothing returned
  input wire logic        emcy_valid,
  input wire logic [7:0]  emcy_byte,
  input wire logic        emcy_last,
  // collected message
  output logic     [63:0] msg,
  output logic     [7:0]  msg_cnt
);
  logic [63:0] shift;
  // ====================
  // first byte ends up highest
  always_ff @(posedge clk or negedge rst_b)
    if (!rst_b)
    begin
      shift   <= 64'h0;
      msg     <= 64'h0;
      msg_cnt <= 8'h00;
    end
    else if (emcy_valid)
    begin
      shift <= {shift[55:0], emcy_byte};
      if (emcy_last)
      begin
        msg     <= {shift[55:0], emcy_byte};
        msg_cnt <= msg_cnt + 8'h01;
      end
    end
endmodule : cdp_master_model

// file: test/test_coupler_diag_process_image.sv
// testbench of the diagnostic and process image block
`timescale 1ns/1ps
module test_coupler_diag_process_image;
  logic        clk, rst_b, mod_stb, bus_stb, stored, ack, sm_clear;
  logic        order_wr, nv_valid, al_error, pi_module, order_nv_wr;
  logic        emcy_valid, emcy_last;
  logic [6:0]  sm_err;
  logic [15:0] bus_state, mod_code, mod_pos, bus_slot, bus_code;
  logic [15:0] al_code, pi_addr, pi_module_addr, mbx_data;
  logic [7:0]  mod_loc, mod_prio, pi_data, emcy_byte, msg_cnt;
  logic [1:0]  pi_sm, mbx_word, item_width;
  logic [2:0]  order_wdata, order_nv, order;
  logic [63:0] item_in, item_out, msg;
  int          fail_count, tests_run, cycles;
  // ====================
  // design and master
  cdp_top u_dut (.CLK(clk), .RST_B(rst_b), .BUS_STATE(bus_state),
    .MOD_ERR_STB(mod_stb), .MOD_ERR_CODE(mod_code), .MOD_ERR_POS(mod_pos),
    .MOD_ERR_LOC(mod_loc), .MOD_ERR_PRIO(mod_prio), .BUS_ERR_STB(bus_stb),
    .BUS_ERR_SLOT(bus_slot), .BUS_ERR_CODE(bus_code),
    .DIAG_STORED_STB(stored), .DIAG_ACK_STB(ack),
    .SM_ERR_BAD_CHANGE(sm_err[0]), .SM_ERR_UNKNOWN(sm_err[1]),
    .SM_ERR_MBX_CFG(sm_err[2]), .SM_ERR_WATCHDOG(sm_err[3]),
    .SM_ERR_OUT_CFG(sm_err[4]), .SM_ERR_IN_CFG(sm_err[5]),
    .SM_ERR_NO_SYNC(sm_err[6]), .SM_ERR_CLEAR(sm_clear),
    .AL_ERROR(al_error), .AL_CODE(al_code), .PI_SM(pi_sm),
    .PI_ADDR(pi_addr), .PI_DATA(pi_data), .PI_MODULE(pi_module),
    .PI_MODULE_ADDR(pi_module_addr), .MBX_WORD(mbx_word),
    .MBX_DATA(mbx_data), .ORDER_WR(order_wr), .ORDER_WDATA(order_wdata),
    .ORDER_NV(order_nv), .ORDER_NV_VALID(nv_valid), .ORDER(order),
    .ORDER_NV_WR(order_nv_wr), .ITEM_IN(item_in),
    .ITEM_WIDTH(item_width), .ITEM_OUT(item_out),
    .EMCY_VALID(emcy_valid), .EMCY_BYTE(emcy_byte),
    .EMCY_LAST(emcy_last));
  cdp_master_model u_master (.clk(clk), .rst_b(rst_b),
    .emcy_valid(emcy_valid), .emcy_byte(emcy_byte),
    .emcy_last(emcy_last), .msg(msg), .msg_cnt(msg_cnt));
  always #25 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      fail_count++;
      complete_run();
    end
  end
  // ====================
  // shared tasks
  task automatic tick();
    @(posedge clk);
    #5;
  endtask : tick
  task automatic check(input string name, input logic [63:0] seen,
                       input logic [63:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic do_reset();
    rst_b = 1'b0;
    repeat (20) tick();
    rst_b = 1'b1;
    tick();
    tick();
  endtask : do_reset
  task automatic complete_run();
    if (fail_count == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : complete_run
  function automatic logic [63:0] swapped(input logic [63:0] d,
                                          input int n, input logic le);
    logic [63:0] r;
    r = d;
    if (le)
      for (int b = 0; b < n; b++)
        r[8*b +: 8] = d[8*(n-1-b) +: 8];
    return r;
  endfunction : swapped
  // ====================
  // scenarios
  task automatic t_record();
    logic [7:0] e [8];
    e = '{8'h01, 8'h00, 8'h5A, 8'hA5, 8'h34, 8'h12, 8'h03, 8'h02};
    bus_state = 16'hA55A;
    mod_code = 16'h1234;
    mod_pos = 16'h0203;
    mod_loc = 8'h41;
    mod_prio = 8'h07;
    mod_stb = 1'b1;
    stored = 1'b1;
    tick();
    mod_stb = 1'b0;
    stored = 1'b0;
    repeat (10) tick();
    check("io message", msg, 64'h1234800203410700);
    pi_sm = 2'h3;
    for (int i = 0; i < 8; i++)
    begin
      pi_addr = 16'(i);
      mbx_word = 2'(i / 2);
      tick();
      check("record byte", pi_data, e[i]);
      if (i % 2 == 1)
        check("mailbox", mbx_data, (i < 2) ? 16'h0 : {e[i], e[i-1]});
    end
    pi_addr = 16'h8;
    tick();
    check("module flag", pi_module, 1'b1);
    check("module addr", pi_module_addr, 16'h0000);
    check("module byte", pi_data, 8'h00);
    ack = 1'b1;
    pi_addr = 16'h0;
    tick();
    ack = 1'b0;
    tick();
    check("flag cleared", pi_data, 8'h00);
    stored = 1'b1;
    ack = 1'b1;
    tick();
    stored = 1'b0;
    ack = 1'b0;
    tick();
    check("flag set wins", pi_data, 8'h01);
  endtask : t_record
  task automatic t_bus();
    bus_slot = 16'h0005;
    bus_code = 16'hBEEF;
    bus_stb = 1'b1;
    tick();
    bus_stb = 1'b0;
    tick();
    bus_stb = 1'b1;
    tick();
    bus_stb = 1'b0;
    repeat (12) tick();
    check("bus message", msg, 64'h1000800005BEEF00);
    check("message count", msg_cnt, 8'h02);
  endtask : t_bus
  task automatic t_al();
    logic [15:0] c [7];
    c = '{16'h0011, 16'h0012, 16'h0016, 16'h001B, 16'h001D, 16'h001E,
          16'h0028};
    for (int i = 0; i < 7; i++)
    begin
      sm_err = 7'(1 << i);
      tick();
      sm_err = 7'h00;
      check("status bit", al_error, 1'b1);
      check("status code", al_code, c[i]);
      sm_clear = 1'b1;
      tick();
      sm_clear = 1'b0;
      check("cleared", {al_error, al_code}, 17'h0);
    end
  endtask : t_al
  task automatic t_order();
    logic [2:0] cfg;
    logic       le;
    cfg = 3'h5;
    nv_valid = 1'b1;
    order_nv = cfg;
    do_reset();
    nv_valid = 1'b0;
    check("stored order", order, 3'h5);
    for (int k = 0; k < 2; k++)
    begin
      for (int w = 0; w < 4; w++)
      begin
        item_in = 64'h1122334455667788 >> (8 * (8 - (1 << w)));
        item_width = 2'(w);
        le = (w == 0) ? 1'b0 : cfg[w-1];
        tick();
        check("item", item_out, swapped(item_in, 1 << w, le));
      end
      cfg = (k == 0) ? 3'h2 : 3'h5;
      order_wdata = cfg;
      order_wr = 1'b1;
      tick();
      order_wr = 1'b0;
      check("order write", {order, order_nv_wr}, {cfg, 1'b1});
    end
  endtask : t_order
  initial
  begin
    clk = 1'b0;
    rst_b = 1'b0;
    {mod_stb, bus_stb, stored, ack, sm_clear, order_wr, nv_valid} = '0;
    {sm_err, bus_state, mod_code, mod_pos, bus_slot, bus_code} = '0;
    {mod_loc, mod_prio, pi_sm, pi_addr, mbx_word, order_wdata} = '0;
    {order_nv, item_in, item_width} = '0;
    do_reset();
    check("order reset", order, 3'h7);
    check("status reset", {al_error, al_code}, 17'h0);
    t_record();
    t_bus();
    t_al();
    t_order();
    complete_run();
  end
endmodule : test_coupler_diag_process_image
bind cdp_top cdp_top_checker u_chk (.CLK(CLK), .RST_B(RST_B),
  .SM_ERR_BAD_CHANGE(SM_ERR_BAD_CHANGE), .BUS_ERR_STB(BUS_ERR_STB),
  .PI_SM(PI_SM), .PI_ADDR(PI_ADDR), .MBX_WORD(MBX_WORD),
  .ORDER_WR(ORDER_WR), .ORDER_WDATA(ORDER_WDATA), .AL_ERROR(AL_ERROR),
  .AL_CODE(AL_CODE), .PI_DATA(PI_DATA), .PI_MODULE(PI_MODULE),
  .PI_MODULE_ADDR(PI_MODULE_ADDR), .MBX_DATA(MBX_DATA), .ORDER(ORDER),
  .ORDER_NV_WR(ORDER_NV_WR), .EMCY_VALID(EMCY_VALID),
  .EMCY_BYTE(EMCY_BYTE), .EMCY_LAST(EMCY_LAST));
